//--- inc/fepc_params.svh
// Constant definitions for the flash erase/protect command controller
`ifndef FEPC_PARAMS_SVH
`define FEPC_PARAMS_SVH
// Flash command codes
`define FEPC_CMD_READ 8'hff
`define FEPC_CMD_ERASE_SETUP 8'h20
`define FEPC_CMD_CONFIRM 8'hd0
`define FEPC_CMD_PROGRAM 8'h40
`define FEPC_CMD_CLEAR_STATUS 8'h50
`define FEPC_CMD_READ_STATUS 8'h70
`define FEPC_CMD_ID_ENTRY 8'h90
`define FEPC_CMD_OTP_SETUP 8'hc0
`define FEPC_LOCK_B_DATA 16'hfffd
`define FEPC_LOCK_B_ADDR 21'h000080
// Protection block word range, high address bits zero
`define FEPC_OTP_FIRST 21'h000081
`define FEPC_OTP_LAST 21'h000088
// Status bit positions
`define FEPC_SR_READY 7
`define FEPC_SR_ERASE_FAIL 5
`define FEPC_SR_PROG_FAIL 4
`define FEPC_SR_SUPPLY 3
`define FEPC_SR_LOCKED 1
`define FEPC_USER_LOCK_BIT 1
// AHB register byte offsets
`define FEPC_REG_CTRL 8'h00
`define FEPC_REG_ADDR 8'h04
`define FEPC_REG_DATA 8'h08
`define FEPC_REG_STAT 8'h0c
`define FEPC_REG_RDATA 8'h10
// Control register fields
`define FEPC_CTRL_GO 31
`define FEPC_OP_LSB 0
`define FEPC_OP_MSB 2
// Pin timing, ns and derived 8 ns cycles
`define FEPC_CLK_NS 8
`define FEPC_T_STROBE_NS 70
`define FEPC_T_STROBE_CYC ((`FEPC_T_STROBE_NS + `FEPC_CLK_NS - 1) / `FEPC_CLK_NS)
`define FEPC_T_READ_NS 90
`define FEPC_T_READ_CYC ((`FEPC_T_READ_NS + `FEPC_CLK_NS - 1) / `FEPC_CLK_NS)
`endif

//--- inc/fepc_pkg.sv
// Types for the flash erase/protect command controller
package fepc_pkg;
   typedef enum logic [2:0]
   {
      fepc_op_erase = 3'h0,
      fepc_op_otp_program = 3'h1,
      fepc_op_clear_status = 3'h2,
      fepc_op_read_array = 3'h3,
      fepc_op_lock_user = 3'h4,
      fepc_op_query_lock = 3'h5,
      fepc_op_word_program = 3'h6,
      fepc_op_read_status = 3'h7
   } fepc_op_type;

   typedef enum logic [2:0]
   {
      fepc_st_idle = 3'h0,
      fepc_st_write = 3'h1,
      fepc_st_gap = 3'h2,
      fepc_st_read = 3'h3,
      fepc_st_poll = 3'h4,
      fepc_st_done = 3'h5
   } fepc_state_type;

   typedef struct packed
   {
      logic [20:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
   } fepc_pins_type;

   typedef struct packed
   {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } fepc_ahb_in_type;

   typedef struct packed
   {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } fepc_ahb_out_type;
endpackage

//--- rtl/fepc_ctrl.sv
// Host-side sequencer driving a parallel NOR flash from AHB-Lite registers
`timescale 1ns/1ns
`include "fepc_params.svh"
module fepc_ctrl
   import fepc_pkg::*;
#(
   parameter int STROBE_CYC = `FEPC_T_STROBE_CYC,
   parameter int READ_CYC = `FEPC_T_READ_CYC
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // AHB-Lite slave
   input wire fepc_ahb_in_type ahb_in,
   output fepc_ahb_out_type ahb_out,
   // Flash pins
   output fepc_pins_type pins,
   input wire logic [15:0] dq_in
);
   initial
   begin
      if (STROBE_CYC < 1 || STROBE_CYC > 255 || READ_CYC < 1 || READ_CYC > 255)
         $error("fepc_ctrl: strobe counts must lie in 1..255");
   end

   typedef struct packed
   {
      fepc_state_type state;
      fepc_ahb_out_type bus;
      fepc_pins_type pins;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [20:0] addr;
      logic [15:0] wdata;
      fepc_op_type op;
      logic busy;
      logic refused;
      logic addr_err;
      logic [1:0] step;
      logic [7:0] status;
      logic [15:0] rdata;
      logic [7:0] cnt;
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] s3;
   } fepc_regs_type;

   fepc_regs_type r, n;

   // True when a command's first cycle must be refused by current error flags
   function automatic logic refuse_op(input fepc_op_type op, input logic [7:0] st);
      logic res;
      res = 1'b0;
      if (op == fepc_op_erase)
         res = st[`FEPC_SR_LOCKED] | st[`FEPC_SR_SUPPLY];
      else if (op == fepc_op_word_program || op == fepc_op_otp_program)
         res = st[`FEPC_SR_SUPPLY];
      return res;
   endfunction

   // Command cycle count of each operation; read status and query lock return two but issue one
   function automatic logic [1:0] op_cycles(input fepc_op_type op);
      logic [1:0] c;
      c = 2'h2;
      if (op == fepc_op_clear_status || op == fepc_op_read_array)
         c = 2'h1;
      return c;
   endfunction

   logic otp_in_range;
   assign otp_in_range = (r.addr >= `FEPC_OTP_FIRST) && (r.addr <= `FEPC_OTP_LAST);

   always_comb
   begin
      logic [7:0] code;
      logic [15:0] word;
      code = 8'h00;
      word = 16'h0000;
      n = r;
      n.s1 = dq_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.bus.hreadyout = 1'b1;
      n.bus.hresp = 1'b0;
      // AHB data phase for writes; the address phase is latched below
      if (r.wr_pend)
      begin
         n.wr_pend = 1'b0;
         unique case (r.wr_addr)
            `FEPC_REG_CTRL:
            begin
               if (ahb_in.hwdata[`FEPC_CTRL_GO] && !r.busy)
               begin
                  n.op = fepc_op_type'(ahb_in.hwdata[`FEPC_OP_MSB:`FEPC_OP_LSB]);
                  n.refused = refuse_op(n.op, r.status);
                  n.addr_err = 1'b0;
                  if (!n.refused)
                  begin
                     n.busy = 1'b1;
                     n.step = 2'h0;
                     n.state = fepc_st_write;
                  end
               end
            end
            `FEPC_REG_ADDR: n.addr = ahb_in.hwdata[20:0];
            `FEPC_REG_DATA: n.wdata = ahb_in.hwdata[15:0];
            default: n.wr_pend = 1'b0;
         endcase
      end
      if (ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1])
      begin
         n.wr_pend = ahb_in.hwrite;
         n.wr_addr = ahb_in.haddr[7:0];
         unique case (ahb_in.haddr[7:0])
            `FEPC_REG_CTRL: n.bus.hrdata = {r.busy, 26'h0000000, r.refused, r.addr_err, r.op};
            `FEPC_REG_ADDR: n.bus.hrdata = {11'h000, r.addr};
            `FEPC_REG_DATA: n.bus.hrdata = {16'h0000, r.wdata};
            `FEPC_REG_STAT: n.bus.hrdata = {24'h000000, r.status};
            `FEPC_REG_RDATA: n.bus.hrdata = {16'h0000, r.rdata};
            default: n.bus.hrdata = 32'h00000000;
         endcase
      end
      // Command word for the current bus cycle, low byte only matters
      unique case (r.op)
         fepc_op_erase: code = (r.step == 2'h0) ? `FEPC_CMD_ERASE_SETUP : `FEPC_CMD_CONFIRM;
         fepc_op_otp_program: code = `FEPC_CMD_OTP_SETUP;
         fepc_op_clear_status: code = `FEPC_CMD_CLEAR_STATUS;
         fepc_op_read_array: code = `FEPC_CMD_READ;
         fepc_op_lock_user: code = `FEPC_CMD_OTP_SETUP;
         fepc_op_query_lock: code = `FEPC_CMD_ID_ENTRY;
         fepc_op_word_program: code = `FEPC_CMD_PROGRAM;
         fepc_op_read_status: code = `FEPC_CMD_READ_STATUS;
      endcase
      word = {8'h00, code};
      if (r.step == 2'h1)
      begin
         if (r.op == fepc_op_otp_program || r.op == fepc_op_word_program)
            word = r.wdata;
         else if (r.op == fepc_op_lock_user)
            word = `FEPC_LOCK_B_DATA;
      end
      unique case (r.state)
         fepc_st_idle:
         begin
            n.pins.ce_n = 1'b1;
            n.pins.oe_n = 1'b1;
            n.pins.we_n = 1'b1;
            n.pins.dq_oe = 1'b0;
         end
         fepc_st_write:
         begin
            // Sector commands reuse the caller's word address as sector select
            n.pins.addr = (r.op == fepc_op_lock_user || r.op == fepc_op_query_lock)
               ? `FEPC_LOCK_B_ADDR : r.addr;
            if (r.op == fepc_op_otp_program && r.step == 2'h0 && r.pins.we_n
               && !otp_in_range)
            begin
               // Stop before the setup cycle so the flash is never left waiting
               // for a data word that a later command would be taken
               n.addr_err = 1'b1;
               n.pins.we_n = 1'b1;
               n.pins.ce_n = 1'b1;
               n.state = fepc_st_done;
            end
            else if (r.pins.we_n)
            begin
               n.pins.dq_out = word;
               n.pins.dq_oe = 1'b1;
               n.pins.ce_n = 1'b0;
               n.pins.we_n = 1'b0;
               n.cnt = 8'(STROBE_CYC);
            end
            else if (r.cnt > 8'h01)
               n.cnt = r.cnt - 8'h01;
            else
            begin
               n.pins.we_n = 1'b1;
               n.pins.ce_n = 1'b1;
               n.state = fepc_st_gap;
            end
         end
         fepc_st_gap:
         begin
            n.pins.dq_oe = 1'b0;
            if (r.step == 2'h0 && op_cycles(r.op) == 2'h2 && r.op != fepc_op_read_status
               && r.op != fepc_op_query_lock)
            begin
               n.step = 2'h1;
               n.state = fepc_st_write;
            end
            else if (r.op == fepc_op_read_array)
               n.state = fepc_st_done;
            else
            begin
               n.cnt = 8'(READ_CYC);
               n.state = fepc_st_read;
               n.pins.ce_n = 1'b0;
               n.pins.oe_n = 1'b0;
            end
         end
         fepc_st_read:
         begin
            if (r.cnt > 8'h01)
               n.cnt = r.cnt - 8'h01;
            else
            begin
               // Take the sample only when two late stages agree on a settled bus
               if (r.s2 == r.s3)
               begin
                  n.pins.ce_n = 1'b1;
                  n.pins.oe_n = 1'b1;
                  n.rdata = r.s3;
                  if (r.op == fepc_op_query_lock)
                     n.state = fepc_st_done;
                  else
                  begin
                     n.status = r.s3[7:0];
                     n.state = fepc_st_poll;
                  end
               end
            end
         end
         fepc_st_poll:
         begin
            // Release CE one cycle so the next read sees refreshed status
            if (r.status[`FEPC_SR_READY] || r.op == fepc_op_clear_status
               || r.op == fepc_op_read_status)
               n.state = fepc_st_done;
            else
            begin
               n.cnt = 8'(READ_CYC);
               n.pins.ce_n = 1'b0;
               n.pins.oe_n = 1'b0;
               n.state = fepc_st_read;
            end
         end
         fepc_st_done:
         begin
            n.busy = 1'b0;
            n.state = fepc_st_idle;
         end
         default: n.state = fepc_st_idle;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         r <= '0;
         r.bus.hreadyout <= 1'b1;
         r.pins.ce_n <= 1'b1;
         r.pins.oe_n <= 1'b1;
         r.pins.we_n <= 1'b1;
         r.status <= 8'h80;
      end
      else
         r <= n;
   end

   assign ahb_out = r.bus;
   assign pins = r.pins;
endmodule

//--- testbench/fepc_ctrl_properties.sv
// Pin and bus timing checks for the flash command controller
`timescale 1ns/1ns
module fepc_ctrl_properties
   import fepc_pkg::*;
#(
   parameter int STROBE_CYC = 9,
   parameter int READ_CYC = 12
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Bus and pins
   input wire fepc_ahb_in_type ahb_in,
   input wire fepc_ahb_out_type ahb_out,
   input wire fepc_pins_type pins,
   input wire logic [15:0] dq_in
);
   logic [7:0] we_cnt_r;
   logic [7:0] oe_cnt_r;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Low-time counters, cleared while the strobe is high
   always_ff @(posedge clock)
   begin
      we_cnt_r <= (reset || pins.we_n) ? 8'h00 : we_cnt_r + 8'h01;
      oe_cnt_r <= (reset || pins.oe_n) ? 8'h00 : oe_cnt_r + 8'h01;
   end
   a_we_width: assert property ($rose(pins.we_n) |-> we_cnt_r == STROBE_CYC)
      else $error("write strobe width wrong");
   a_read_width: assert property ($rose(pins.oe_n) |-> oe_cnt_r >= READ_CYC)
      else $error("read strobe too short");
   a_we_needs_ce: assert property (!pins.we_n |-> !pins.ce_n)
      else $error("write strobe without chip select");
   a_no_contention: assert property (!pins.oe_n |-> !pins.dq_oe && pins.we_n)
      else $error("data driven during read");
   a_drive_write: assert property (!pins.we_n |-> pins.dq_oe)
      else $error("data not driven during write");
   a_cmd_stable: assert property (!pins.we_n && $past(!pins.we_n) |->
      $stable(pins.dq_out) && $stable(pins.addr))
      else $error("command changed inside strobe");
   a_poll_toggle: assert property ($fell(pins.oe_n) |-> $past(pins.ce_n))
      else $error("status read without chip select toggle");
   a_bus_okay: assert property (ahb_out.hreadyout && !ahb_out.hresp)
      else $error("bus answer not ready okay");
endmodule
bind fepc_ctrl fepc_ctrl_properties #(.STROBE_CYC(STROBE_CYC), .READ_CYC(READ_CYC)) chk_u
   (.clock(clock), .reset(reset), .ahb_in(ahb_in), .ahb_out(ahb_out), .pins(pins),
    .dq_in(dq_in));

//--- testbench/fepc_flash_model.sv
// Behavioural flash device answering the controller's pins
`timescale 1ns/1ns
module fepc_flash_model
   import fepc_pkg::*;
#(
   parameter logic [5:0] LOCKED_SECT = 6'h03,
   parameter logic [5:0] FAIL_SECT = 6'h3f,
   parameter int BUSY_NS = 400
)
(
   // Pins
   input wire fepc_pins_type pins,
   output logic [15:0] dq_in
);
   logic [7:0] sr = 8'h80;
   logic [7:0] prev = 8'h00;
   logic [7:0] cmd;
   logic [1:0] mode = 2'h0;
   logic lock_b = 1'b0;
   logic [15:0] otp [8];
   logic [15:0] rd;
   int erases = 0;
   always @(negedge pins.we_n)
   begin
      #1;
      cmd = pins.dq_out[7:0];
      if (prev == 8'h20)
      begin
         mode = 2'h1;
         if (cmd != 8'hd0)
            sr[5:4] = 2'b11;
         else if (!sr[1] && !sr[3])
         begin
            if (pins.addr[20:15] == LOCKED_SECT)
               sr[1] = 1'b1;
            else if (pins.addr[20:15] == FAIL_SECT)
               sr[5] = 1'b1;
            else
            begin
               sr[7] = 1'b0;
               erases++;
               #BUSY_NS sr[7] = 1'b1;
            end
         end
         prev = 8'h00;
      end
      else if (prev == 8'hc0)
      begin
         mode = 2'h1;
         if (pins.addr == 21'h000080)
            lock_b = 1'b1;
         else if (pins.addr >= 21'h000081 && pins.addr <= 21'h000088 && !sr[3])
            otp[pins.addr[3:0] - 4'h1] = pins.dq_out;
         else
            sr[4] = 1'b1;
         prev = 8'h00;
      end
      else
      begin
         prev = cmd;
         case (cmd)
            8'hff: mode = 2'h0;
            8'h70: mode = 2'h1;
            8'h90: mode = 2'h2;
            8'h50: sr[5:1] = 5'h00;
            default: ;
         endcase
      end
   end
   // Status is rebuilt on every read so polling sees fresh values
   always_comb
      case (mode)
         2'h1: rd = {8'h00, sr};
         2'h2: rd = {14'h0000, !lock_b, 1'b0};
         default: rd = pins.addr[15:0] ^ 16'h5a5a;
      endcase
   // No pull-ups: an idle bus shows the inverse value
   assign dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
endmodule

//--- testbench/tb_top.sv
// Register-level test of the flash command controller
`timescale 1ns/1ns
module tb_top
   import fepc_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] r;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   fepc_ahb_in_type ahb_in;
   fepc_ahb_out_type ahb_out;
   fepc_pins_type pins;
   logic [15:0] dq_in;
   assign ahb_in = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahb_out.hreadyout};
   fepc_ctrl #(.STROBE_CYC(2), .READ_CYC(3)) dut_u (.clock(clock), .reset(reset),
      .ahb_in(ahb_in), .ahb_out(ahb_out), .pins(pins), .dq_in(dq_in));
   fepc_flash_model flash_u (.pins(pins), .dq_in(dq_in));
   always #4 clock = ~clock;
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         miscompares++;
         test_done();
      end
   end
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clock); while (!ahb_out.hreadyout);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (!ahb_out.hreadyout);
      r = ahb_out.hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input fepc_op_type o, input logic [20:0] a);
      bus(1'b1, 8'h04, {11'h0, a});
      bus(1'b1, 8'h00, {1'b1, 28'h0, o});
      do bus(1'b0, 8'h00, 32'h0); while (r[31] !== 1'b0);
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      bus(1'b0, 8'h0c, 32'h0); chk(r, 32'h80);
      bus(1'b0, 8'h20, 32'h0); chk(r, 32'h0);
      op(fepc_op_erase, 21'h010123); bus(1'b0, 8'h0c, 0); chk(r, 32'h80);
      chk(flash_u.erases, 1);
      op(fepc_op_erase, 21'h01a004); bus(1'b0, 8'h0c, 0); chk(r, 32'h82);
      op(fepc_op_erase, 21'h010000); chk(r, 32'h10);
      chk(flash_u.erases, 1);
      op(fepc_op_read_status, 21'h0); bus(1'b0, 8'h0c, 0); chk(r, 32'h82);
      op(fepc_op_clear_status, 21'h0); bus(1'b0, 8'h0c, 0); chk(r, 32'h80);
      bus(1'b1, 8'h08, 32'h1234);
      op(fepc_op_otp_program, 21'h000085); chk(flash_u.otp[4], 16'h1234);
      op(fepc_op_otp_program, 21'h100085); chk(r, 32'h09);
      op(fepc_op_query_lock, 21'h0); bus(1'b0, 8'h10, 0); chk(r & 32'h2, 32'h2);
      op(fepc_op_lock_user, 21'h0);
      op(fepc_op_query_lock, 21'h0); bus(1'b0, 8'h10, 0); chk(r & 32'h2, 32'h0);
      op(fepc_op_read_array, 21'h000007); chk(flash_u.mode, 32'h0);
      bus(1'b0, 8'h10, 0); chk(r, 32'h0);
      test_done();
   end
endmodule
